/* design/dpll_ref_defs.vh */
// Register map, field positions, reset values and decode tables
`ifndef DPLL_REF_DEFS_VH
`define DPLL_REF_DEFS_VH

// ==========================================================
// Register offsets
`define ADDR_LOOP_A_MASKS      8'h39
`define ADDR_LOOP_B_CONTROL    8'h3A
`define ADDR_LOOP_B_PRIO_UPPER 8'h3B
`define ADDR_IRQ_STATUS        8'h40
`define ADDR_IRQ_MASK          8'h41
`define ADDR_LOOP_STATUS       8'h42

// ==========================================================
// Reset values
`define RST_LOOP_A_MASKS       8'h87
`define RST_LOOP_B_CONTROL     8'h0D
`define RST_LOOP_B_PRIO_UPPER  8'h32
`define RST_IRQ_MASK           8'h00

// ==========================================================
// Field positions
`define MON_LOSS               0
`define MON_SINGLE_CYCLE       1
`define MON_COARSE_FREQ        2
`define MON_GUARD_SOAK         3
`define CTRL_PHASE_ALIGN_BIT   4
`define PRIO_RESERVED_MASK     8'h77
`define RANK_DISABLED          3'h7
`define BW_RESERVED_CODE       3'h7

// ==========================================================
// Interrupt status bits
`define IRQ_B_SWITCH           0
`define IRQ_B_HOLD_ENTER       1
`define IRQ_B_HOLD_EXIT        2
`define IRQ_A_HOLD_REQ         3
`define IRQ_A_SWITCH_REQ       4
`define IRQ_USED_MASK          8'h1F

// ==========================================================
// Lock range in ppm
`define RANGE_PPM_0            12'd52
`define RANGE_PPM_1            12'd130
`define RANGE_PPM_2            12'd400
`define RANGE_PPM_3            12'd3900

// ==========================================================
// Phase slope limit in ns per second
`define SLOPE_NS_0             16'd61000
`define SLOPE_NS_1             16'd7500
`define SLOPE_NS_2             16'd885

// ==========================================================
// Loop bandwidth in Hz
`define BW_HZ_BASE             10'd14

`endif

/* design/dpll_ref_fail_mask_and_ctrl.v */
// Reference failure masks and second loop control with selection
`include "dpll_ref_defs.vh"
`default_nettype none

module dpll_ref_fail_mask_and_ctrl #(
    parameter ADDR_W = 8,
    parameter DATA_W = 8
) (
    // Clock and reset
    input  wire              clk_sys,
    input  wire              sys_rst,
    // Register port
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [DATA_W-1:0] reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [DATA_W-1:0] reg_rdata,
    // Monitor flags, four per reference, reference 0 lowest
    input  wire [15:0]       ref_mon_fail,
    // First loop context
    input  wire [1:0]        loop_a_cur_ref,
    // Second loop context
    input  wire              loop_b_auto_mode,
    input  wire [1:0]        loop_b_forced_ref,
    input  wire [2:0]        loop_b_first_ref_rank,
    input  wire [2:0]        loop_b_second_ref_rank,
    // First loop qualified failures and illegal mask flag
    output reg               loop_a_hold_req,
    output reg               loop_a_switch_req,
    output reg               loop_a_mask_illegal,
    // Second loop settings
    output reg  [11:0]       loop_b_lock_range_ppm,
    output reg  [15:0]       loop_b_slope_ns_per_s,
    output reg  [9:0]        loop_b_bandwidth_hz,
    output reg               loop_b_bandwidth_reserved,
    output reg               loop_b_phase_align_clear,
    // Second loop selection
    output reg  [1:0]        loop_b_sel_ref,
    output reg               loop_b_holdover,
    // Interrupt
    output wire              irq
);

    // ======================================================
    // Registers
    reg  [7:0] loop_a_failure_masks_reg;
    reg  [7:0] loop_b_control_reg;
    reg  [7:0] loop_b_priority_upper_refs_reg;
    reg  [7:0] irq_status_reg;
    reg  [7:0] irq_status_next;
    reg  [7:0] irq_mask_reg;
    reg  [1:0] sel_ref_reg;
    reg  [1:0] sel_ref_next;
    reg        holdover_reg;
    reg        holdover_next;
    reg        a_hold_reg;
    reg        a_switch_reg;

    wire [3:0] loop_a_hold_suppress_bits;
    wire [3:0] loop_a_switch_suppress_bits;
    wire [1:0] loop_b_lock_range;
    wire [1:0] loop_b_slope_limit;
    wire       loop_b_phase_align_bit;
    wire [2:0] loop_b_bandwidth;
    wire [2:0] loop_b_third_ref_rank;
    wire [2:0] loop_b_fourth_ref_rank;

    wire [3:0] ref_hold_fail;
    wire [3:0] ref_switch_fail;
    wire [3:0] ref_avail;
    wire [1:0] best_ref;
    wire       none_avail;

    wire       wr_masks;
    wire       wr_ctrl;
    wire       wr_prio;
    wire       wr_irq_status;
    wire       wr_irq_mask;

    // ======================================================
    // Field views
    assign loop_a_hold_suppress_bits   = loop_a_failure_masks_reg[3:0];
    assign loop_a_switch_suppress_bits = loop_a_failure_masks_reg[7:4];
    assign loop_b_lock_range           = loop_b_control_reg[1:0];
    assign loop_b_slope_limit          = loop_b_control_reg[3:2];
    assign loop_b_phase_align_bit      =
        loop_b_control_reg[`CTRL_PHASE_ALIGN_BIT];
    assign loop_b_bandwidth            = loop_b_control_reg[7:5];
    assign loop_b_third_ref_rank       = loop_b_priority_upper_refs_reg[2:0];
    assign loop_b_fourth_ref_rank      = loop_b_priority_upper_refs_reg[6:4];

    // ======================================================
    // Write decode
    assign wr_masks      = reg_wr && reg_addr == `ADDR_LOOP_A_MASKS;
    assign wr_ctrl       = reg_wr && reg_addr == `ADDR_LOOP_B_CONTROL;
    assign wr_prio       = reg_wr && reg_addr == `ADDR_LOOP_B_PRIO_UPPER;
    assign wr_irq_status = reg_wr && reg_addr == `ADDR_IRQ_STATUS;
    assign wr_irq_mask   = reg_wr && reg_addr == `ADDR_IRQ_MASK;

    // ======================================================
    // Configuration registers
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            loop_a_failure_masks_reg       <= `RST_LOOP_A_MASKS;
            loop_b_control_reg             <= `RST_LOOP_B_CONTROL;
            loop_b_priority_upper_refs_reg <= `RST_LOOP_B_PRIO_UPPER;
            irq_mask_reg                   <= `RST_IRQ_MASK;
        end else begin
            if (wr_masks) begin
                loop_a_failure_masks_reg <= reg_wdata;
            end
            if (wr_ctrl) begin
                loop_b_control_reg <= reg_wdata;
            end
            // Reserved bits 3 and 7 keep their default
            if (wr_prio) begin
                loop_b_priority_upper_refs_reg <=
                    (reg_wdata & `PRIO_RESERVED_MASK) |
                    (`RST_LOOP_B_PRIO_UPPER & ~`PRIO_RESERVED_MASK);
            end
            if (wr_irq_mask) begin
                irq_mask_reg <= reg_wdata & `IRQ_USED_MASK;
            end
        end
    end

    // ======================================================
    // Read port, data one cycle after the strobe
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_LOOP_A_MASKS: begin
                    reg_rdata <= loop_a_failure_masks_reg;
                end
                `ADDR_LOOP_B_CONTROL: begin
                    reg_rdata <= loop_b_control_reg;
                end
                `ADDR_LOOP_B_PRIO_UPPER: begin
                    reg_rdata <= loop_b_priority_upper_refs_reg;
                end
                `ADDR_IRQ_STATUS: begin
                    reg_rdata <= irq_status_reg;
                end
                `ADDR_IRQ_MASK: begin
                    reg_rdata <= irq_mask_reg;
                end
                `ADDR_LOOP_STATUS: begin
                    reg_rdata <= {3'h0, loop_a_mask_illegal,
                                  loop_a_switch_req, loop_a_hold_req,
                                  holdover_reg, 1'b0} |
                                 {6'h00, sel_ref_reg} << 0 |
                                 8'h00;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ======================================================
    // First loop failure qualification per reference
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_gate
            fail_gate u_fail_gate (
                .mon_fail    (ref_mon_fail[4*g+3:4*g]),
                .hold_mask   (loop_a_hold_suppress_bits),
                .switch_mask (loop_a_switch_suppress_bits),
                .hold_fail   (ref_hold_fail[g]),
                .switch_fail (ref_switch_fail[g])
            );
        end
    endgenerate

    // Second loop sees a reference as available while no monitor fails
    assign ref_avail = {~|ref_mon_fail[15:12], ~|ref_mon_fail[11:8],
                        ~|ref_mon_fail[7:4],   ~|ref_mon_fail[3:0]};

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            a_hold_reg          <= 1'b0;
            a_switch_reg        <= 1'b0;
            loop_a_mask_illegal <= 1'b0;
        end else begin
            a_hold_reg          <= ref_hold_fail[loop_a_cur_ref];
            a_switch_reg        <= ref_switch_fail[loop_a_cur_ref];
            // Guard bit set with neither companion bit set
            loop_a_mask_illegal <=
                loop_a_hold_suppress_bits[3:1] == 3'b100;
        end
    end

    always @* begin
        loop_a_hold_req   = a_hold_reg;
        loop_a_switch_req = a_switch_reg;
    end

    // ======================================================
    // Second loop settings decode
    always @* begin
        case (loop_b_lock_range)
            2'b00:   loop_b_lock_range_ppm = `RANGE_PPM_0;
            2'b01:   loop_b_lock_range_ppm = `RANGE_PPM_1;
            2'b10:   loop_b_lock_range_ppm = `RANGE_PPM_2;
            default: loop_b_lock_range_ppm = `RANGE_PPM_3;
        endcase
        // Code 3 falls back to the tightest limit
        case (loop_b_slope_limit)
            2'b00:   loop_b_slope_ns_per_s = `SLOPE_NS_0;
            2'b01:   loop_b_slope_ns_per_s = `SLOPE_NS_1;
            default: loop_b_slope_ns_per_s = `SLOPE_NS_2;
        endcase
        // Doubling from 14 Hz; reserved code holds the widest setting
        if (loop_b_bandwidth == `BW_RESERVED_CODE) begin
            loop_b_bandwidth_hz = `BW_HZ_BASE << 6;
        end else begin
            loop_b_bandwidth_hz = `BW_HZ_BASE << loop_b_bandwidth;
        end
        loop_b_bandwidth_reserved = loop_b_bandwidth == `BW_RESERVED_CODE;
        loop_b_phase_align_clear  = loop_b_phase_align_bit;
    end

    // ======================================================
    // Second loop reference selection
    ref_rank_select #(
        .RANK_W (3)
    ) u_select (
        .rank0      (loop_b_first_ref_rank),
        .rank1      (loop_b_second_ref_rank),
        .rank2      (loop_b_third_ref_rank),
        .rank3      (loop_b_fourth_ref_rank),
        .avail      (ref_avail),
        .cur_ref    (sel_ref_reg),
        .best_ref   (best_ref),
        .none_avail (none_avail)
    );

    always @* begin
        sel_ref_next  = sel_ref_reg;
        holdover_next = holdover_reg;
        if (loop_b_auto_mode) begin
            // Holdover keeps the last reference
            if (none_avail) begin
                holdover_next = 1'b1;
            end else begin
                holdover_next = 1'b0;
                sel_ref_next  = best_ref;
            end
        end else begin
            // Manual modes: forced reference, holdover on its failure
            sel_ref_next  = loop_b_forced_ref;
            holdover_next = ~ref_avail[loop_b_forced_ref];
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sel_ref_reg  <= 2'b00;
            holdover_reg <= 1'b0;
        end else begin
            sel_ref_reg  <= sel_ref_next;
            holdover_reg <= holdover_next;
        end
    end

    always @* begin
        loop_b_sel_ref  = sel_ref_reg;
        loop_b_holdover = holdover_reg;
    end

    // ======================================================
    // Interrupt status, set wins over write-one-to-clear
    always @* begin
        irq_status_next = irq_status_reg;
        if (wr_irq_status) begin
            irq_status_next = irq_status_reg & ~reg_wdata;
        end
        if (sel_ref_next != sel_ref_reg) begin
            irq_status_next[`IRQ_B_SWITCH] = 1'b1;
        end
        if (holdover_next && !holdover_reg) begin
            irq_status_next[`IRQ_B_HOLD_ENTER] = 1'b1;
        end
        if (!holdover_next && holdover_reg) begin
            irq_status_next[`IRQ_B_HOLD_EXIT] = 1'b1;
        end
        if (ref_hold_fail[loop_a_cur_ref] && !a_hold_reg) begin
            irq_status_next[`IRQ_A_HOLD_REQ] = 1'b1;
        end
        if (ref_switch_fail[loop_a_cur_ref] && !a_switch_reg) begin
            irq_status_next[`IRQ_A_SWITCH_REQ] = 1'b1;
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_status_reg <= 8'h00;
        end else begin
            irq_status_reg <= irq_status_next & `IRQ_USED_MASK;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

endmodule // dpll_ref_fail_mask_and_ctrl

`default_nettype wire

/* design/fail_gate.v */
// Failure masking for one reference: holdover and switch qualifiers
`default_nettype none

module fail_gate (
    // Monitor flags: loss, single cycle, coarse freq, guard soak
    input  wire [3:0] mon_fail,
    // Masks, a zero suppresses the matching monitor
    input  wire [3:0] hold_mask,
    input  wire [3:0] switch_mask,
    // Qualified failures
    output wire       hold_fail,
    output wire       switch_fail
);

    assign hold_fail   = |(mon_fail & hold_mask);
    assign switch_fail = |(mon_fail & switch_mask);

endmodule // fail_gate

`default_nettype wire

/* design/ref_rank_select.v */
// Priority selection among four references, revertive across ranks
`default_nettype none

module ref_rank_select #(
    parameter RANK_W = 3
) (
    // Rank codes, lower wins, all ones removes the reference
    input  wire [RANK_W-1:0] rank0,
    input  wire [RANK_W-1:0] rank1,
    input  wire [RANK_W-1:0] rank2,
    input  wire [RANK_W-1:0] rank3,
    // Availability and current choice
    input  wire [3:0]        avail,
    input  wire [1:0]        cur_ref,
    // Choice
    output reg  [1:0]        best_ref,
    output reg               none_avail
);

    reg [RANK_W-1:0] rank [0:3];
    reg [3:0]        cand;
    reg [RANK_W-1:0] best_rank;
    integer          i;

    always @* begin
        rank[0] = rank0;
        rank[1] = rank1;
        rank[2] = rank2;
        rank[3] = rank3;
        best_rank = {RANK_W{1'b1}};
        best_ref = cur_ref;
        for (i = 0; i < 4; i = i + 1) begin
            cand[i] = avail[i] && (rank[i] != {RANK_W{1'b1}});
            if (cand[i] && rank[i] < best_rank) begin
                best_rank = rank[i];
            end
        end
        none_avail = ~|cand;
        // Lowest index of the best rank, unless current already shares it
        for (i = 3; i >= 0; i = i - 1) begin
            if (cand[i] && rank[i] == best_rank) begin
                best_ref = i[1:0];
            end
        end
        if (cand[cur_ref] && rank[cur_ref] == best_rank) begin
            best_ref = cur_ref;
        end
    end

endmodule // ref_rank_select

`default_nettype wire

/* sim/dpll_ref_checker.sv */
// Checker for loop B decode, selection and the register port
`default_nettype none

module dpll_ref_checker #(
    parameter ADDR_W = 8,
    parameter DATA_W = 8
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Monitors and loop context
    input wire logic [15:0]       ref_mon_fail,
    input wire logic [1:0]        loop_a_cur_ref,
    input wire logic              loop_b_auto_mode,
    input wire logic [1:0]        loop_b_forced_ref,
    input wire logic [2:0]        loop_b_first_ref_rank,
    // Outputs watched
    input wire logic              loop_a_hold_req,
    input wire logic              loop_a_switch_req,
    input wire logic [11:0]       loop_b_lock_range_ppm,
    input wire logic [15:0]       loop_b_slope_ns_per_s,
    input wire logic [9:0]        loop_b_bandwidth_hz,
    input wire logic              loop_b_bandwidth_reserved,
    input wire logic              loop_b_phase_align_clear,
    input wire logic [1:0]        loop_b_sel_ref,
    input wire logic              loop_b_holdover
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Helpers
    wire       ctrl_wr = reg_wr && (reg_addr == 8'h3A);
    wire [3:0] cur_nib = ref_mon_fail[loop_a_cur_ref*4 +: 4];
    wire       none_ok = (|ref_mon_fail[3:0]) && (|ref_mon_fail[7:4]) &&
                         (|ref_mon_fail[11:8]) && (|ref_mon_fail[15:12]);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Assertions
    chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    chk_rank_reserved: assert property (reg_rd && reg_addr == 8'h3B |=>
        reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("reserved rank bits read as one");
    chk_range_decode: assert property (ctrl_wr |=>
        loop_b_lock_range_ppm == ($past(reg_wdata[1:0]) == 2'h0 ? 12'd52 :
        $past(reg_wdata[1:0]) == 2'h1 ? 12'd130 :
        $past(reg_wdata[1:0]) == 2'h2 ? 12'd400 : 12'd3900))
        else $error("lock range decode wrong");
    chk_slope_decode: assert property (ctrl_wr |=>
        loop_b_slope_ns_per_s == ($past(reg_wdata[3:2]) == 2'h0 ? 16'd61000 :
        $past(reg_wdata[3:2]) == 2'h1 ? 16'd7500 : 16'd885))
        else $error("slope decode wrong");
    chk_bw_decode: assert property (ctrl_wr |=>
        loop_b_bandwidth_reserved == ($past(reg_wdata[7:5]) == 3'h7) &&
        loop_b_bandwidth_hz == ($past(reg_wdata[7:5]) == 3'h7 ? 10'd896 :
        (10'd14 << $past(reg_wdata[7:5]))))
        else $error("bandwidth decode wrong");
    chk_align_bit: assert property (ctrl_wr |=>
        loop_b_phase_align_clear == $past(reg_wdata[4]))
        else $error("phase align bit not applied");
    chk_hold_idle: assert property (cur_nib == 4'h0 |=>
        !loop_a_hold_req && !loop_a_switch_req)
        else $error("loop A request without failure");
    chk_forced_sel: assert property (!loop_b_auto_mode |=>
        loop_b_sel_ref == $past(loop_b_forced_ref))
        else $error("forced reference not followed");
    chk_none_hold: assert property (loop_b_auto_mode && none_ok |=>
        loop_b_holdover)
        else $error("no holdover with all references failing");
    chk_best_kept: assert property (loop_b_auto_mode &&
        ref_mon_fail[3:0] == 4'h0 && loop_b_first_ref_rank == 3'h0 &&
        loop_b_sel_ref == 2'h0 |=> loop_b_sel_ref == 2'h0 && !loop_b_holdover)
        else $error("top rank reference left");

    // ==========================================================
    // Coverage
    cov_bw_res: cover property (ctrl_wr && reg_wdata[7:5] == 3'h7);
    cov_hold: cover property ($rose(loop_b_holdover));
    cov_a_req: cover property ($rose(loop_a_hold_req));
endmodule // dpll_ref_checker

`default_nettype wire

/* sim/tb_dpll_ref_fail_mask_and_ctrl.sv */
// Testbench for reference failure masks and loop B control
`include "dpll_ref_defs.vh"
`default_nettype none

module tb_dpll_ref_fail_mask_and_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, sys_rst, reg_wr, reg_rd, auto_m;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v, m;
    logic [15:0] fail, slope;
    logic [1:0]  cur, forced, sel;
    logic [2:0]  rank0, rank1;
    logic        hreq, sreq, illegal, bw_res, align, hold, irq;
    logic [11:0] ppm;
    logic [9:0]  bw;
    logic [31:0] seed = 32'h0000_0D53;
    int          fail_count = 0;
    int          comparisons = 0;

    dpll_ref_fail_mask_and_ctrl i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ref_mon_fail(fail), .loop_a_cur_ref(cur),
        .loop_b_auto_mode(auto_m), .loop_b_forced_ref(forced),
        .loop_b_first_ref_rank(rank0), .loop_b_second_ref_rank(rank1),
        .loop_a_hold_req(hreq), .loop_a_switch_req(sreq),
        .loop_a_mask_illegal(illegal), .loop_b_lock_range_ppm(ppm),
        .loop_b_slope_ns_per_s(slope), .loop_b_bandwidth_hz(bw),
        .loop_b_bandwidth_reserved(bw_res),
        .loop_b_phase_align_clear(align), .loop_b_sel_ref(sel),
        .loop_b_holdover(hold), .irq(irq));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rc(string what, logic [7:0] a, logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("Watchdog expired");
        stop_test();
    end

    // ==========================================================
    // Main sequence
    logic [7:0]  tp [8] = '{8'h21, 8'h21, 8'h21, 8'h11, 8'h11, 8'h11, 8'h11, 8'h77};
    logic [15:0] tf [8] = '{16'h00FF, 16'h0FFF, 16'h00FF, 16'h0FFF,
                            16'h00FF, 16'h00F0, 16'hFFFF, 16'hFF00};
    logic [2:0]  tr [8] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h0, 3'h0, 3'h7};
    logic [2:0]  ts [8] = '{3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h0, 3'h4, 3'h4};

    initial begin
        {sys_rst, reg_wr, reg_rd, auto_m} = 4'b1001;
        {reg_addr, reg_wdata, fail, cur, forced} = '0;
        {rank0, rank1} = 6'h3F;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rc("masks", `ADDR_LOOP_A_MASKS, `RST_LOOP_A_MASKS);
        rc("ctrl", `ADDR_LOOP_B_CONTROL, `RST_LOOP_B_CONTROL);
        rc("prio", `ADDR_LOOP_B_PRIO_UPPER, `RST_LOOP_B_PRIO_UPPER);
        rc("irq mask", `ADDR_IRQ_MASK, `RST_IRQ_MASK);
        rc("unmapped", 8'h55, 8'h00);
        for (int i = 0; i < 256; i++) begin
            v = i[7:0];
            wr(`ADDR_LOOP_B_CONTROL, v);
            chk("range", v[1:0] == 0 ? 52 : v[1:0] == 1 ? 130 :
                v[1:0] == 2 ? 400 : 3900, ppm);
            chk("slope", v[3:2] == 0 ? 61000 : v[3:2] == 1 ? 7500 : 885, slope);
            chk("bw", v[7:5] == 7 ? 896 : 14 << v[7:5], bw);
            chk("bw res", v[7:5] == 7, bw_res);
            chk("align", v[4], align);
        end
        rc("ctrl back", `ADDR_LOOP_B_CONTROL, 8'hFF);
        repeat (20) begin
            v = rnd();
            wr(`ADDR_LOOP_B_PRIO_UPPER, v);
            rc("prio back", `ADDR_LOOP_B_PRIO_UPPER, v & 8'h77);
        end
        for (int k = 0; k < 40; k++) begin
            m = k == 0 ? 8'h00 : k == 1 ? 8'hFF : k == 2 ? 8'h08 : rnd();
            @(posedge clk_sys);
            fail <= rnd();
            cur <= rnd();
            wr(`ADDR_LOOP_A_MASKS, m);
            repeat (2) @(posedge clk_sys);
            #1;
            chk("hold req", |(fail[cur*4 +: 4] & m[3:0]), hreq);
            chk("switch req", |(fail[cur*4 +: 4] & m[7:4]), sreq);
            chk("illegal", m[3:1] == 3'b100, illegal);
        end
        wr(`ADDR_LOOP_B_CONTROL, 8'h0D);
        chk("align low", 0, align);
        for (int j = 0; j < 8; j++) begin
            @(posedge clk_sys);
            fail <= tf[j];
            rank0 <= tr[j];
            wr(`ADDR_LOOP_B_PRIO_UPPER, tp[j]);
            repeat (3) @(posedge clk_sys);
            #1;
            chk("sel", ts[j] == 4 ? 0 : ts[j], sel);
            chk("hold", ts[j] == 4, hold);
        end
        @(posedge clk_sys);
        {auto_m, forced, fail} <= {3'b001, 16'h0000};
        repeat (3) @(posedge clk_sys);
        #1;
        chk("forced sel", 1, sel);
        @(posedge clk_sys);
        fail <= 16'h00F0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("forced hold", 1, hold);
        @(posedge clk_sys);
        {fail, cur} <= 18'h0;
        wr(`ADDR_IRQ_MASK, 8'h00);
        wr(`ADDR_LOOP_A_MASKS, 8'h0F);
        wr(`ADDR_IRQ_STATUS, 8'h1F);
        chk("irq clear", 0, irq);
        @(posedge clk_sys);
        fail <= 16'h0001;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("irq masked", 0, irq);
        wr(`ADDR_IRQ_MASK, 8'h08);
        chk("irq raised", 1, irq);
        rc("irq mask back", `ADDR_IRQ_MASK, 8'h08);
        rc("irq status", `ADDR_IRQ_STATUS, 8'h08);
        rc("loop status", `ADDR_LOOP_STATUS, 8'h05);
        @(posedge clk_sys);
        fail <= 16'h0000;
        wr(`ADDR_IRQ_STATUS, 8'h08);
        chk("irq cleared", 0, irq);
        stop_test();
    end
endmodule // tb_dpll_ref_fail_mask_and_ctrl

bind dpll_ref_fail_mask_and_ctrl dpll_ref_checker #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ref_mon_fail(ref_mon_fail),
    .loop_a_cur_ref(loop_a_cur_ref), .loop_b_auto_mode(loop_b_auto_mode),
    .loop_b_forced_ref(loop_b_forced_ref),
    .loop_b_first_ref_rank(loop_b_first_ref_rank),
    .loop_a_hold_req(loop_a_hold_req), .loop_a_switch_req(loop_a_switch_req),
    .loop_b_lock_range_ppm(loop_b_lock_range_ppm),
    .loop_b_slope_ns_per_s(loop_b_slope_ns_per_s),
    .loop_b_bandwidth_hz(loop_b_bandwidth_hz),
    .loop_b_bandwidth_reserved(loop_b_bandwidth_reserved),
    .loop_b_phase_align_clear(loop_b_phase_align_clear),
    .loop_b_sel_ref(loop_b_sel_ref), .loop_b_holdover(loop_b_holdover));

`default_nettype wire
